// File: verilog/operand_format_pkg.sv
/*
 * Shared constants and types for the operand format classifier: field
 * widths, exponent biases, class bit positions and alignment masks.
 * Assumes a single core clock domain; nothing here holds state.
 */
package operand_format_pkg;

    // ************************************************************
    // Format selections
    // ************************************************************
    typedef enum logic [1:0] {FMT_SINGLE, FMT_DOUBLE, FMT_QUAD} fp_fmt_t;
    typedef enum logic [1:0] {INT_BYTE, INT_HALF, INT_WORD, INT_DWORD} int_width_t;
    typedef enum logic [1:0] {SIMD_PACKED_UNSIGNED_BYTE_LANES, SIMD_PACKED_SIGNED_HALF_LANES, SIMD_PACKED_SIGNED_WORD_LANES} simd_fmt_t;

    // ************************************************************
    // Floating-point field layout
    // ************************************************************
    localparam int SP_FRAC_W = 23;
    localparam int DP_FRAC_W = 52;
    localparam int QP_FRAC_W = 112;
    localparam int EXP_OUT_W = 15;
    localparam int FRAC_OUT_W = 112;
    localparam int UEXP_W = 17;
    localparam int OPER_W = 128;
    localparam logic [14:0] SP_EXP_MAX = 15'h00ff;
    localparam logic [14:0] DP_EXP_MAX = 15'h07ff;
    localparam logic [14:0] QP_EXP_MAX = 15'h7fff;
    localparam logic signed [16:0] SP_BIAS = 17'sh0007f;
    localparam logic signed [16:0] DP_BIAS = 17'sh003ff;
    localparam logic signed [16:0] QP_BIAS = 17'sh03fff;
    localparam logic signed [16:0] UEXP_ONE = 17'sh00001;

    // ************************************************************
    // Class encoding, one bit per class
    // ************************************************************
    localparam int CLS_W = 6;
    localparam int CLS_NORMAL = 0;
    localparam int CLS_SUBNORMAL = 1;
    localparam int CLS_ZERO = 2;
    localparam int CLS_INF = 3;
    localparam int CLS_SNAN = 4;
    localparam int CLS_QNAN = 5;
    localparam logic [5:0] CLS_RESET = 6'h04;

    // ************************************************************
    // Registers, alignment and packing
    // ************************************************************
    localparam logic [5:0] FP_SINGLE_DIRECT_MAX = 6'h1f;
    localparam logic [3:0] WORD_ALIGN_MASK = 4'h3;
    localparam logic [3:0] DWORD_ALIGN_MASK = 4'h7;
    localparam logic [3:0] QUAD_ALIGN_MASK = 4'hf;
    localparam int BYTE_LANES = 8;
    localparam logic [7:0] LANE_START_PACKED_UNSIGNED_BYTE_LANES = 8'hff;
    localparam logic [7:0] LANE_START_PACKED_SIGNED_HALF_LANES = 8'h55;
    localparam logic [7:0] LANE_START_PACKED_SIGNED_WORD_LANES = 8'h11;
    localparam int TAG_W = 2;

endpackage : operand_format_pkg

// File: verilog/fp_field_decoder.sv
/*
 * Combinational splitter and classifier for one floating-point operand
 * in single, double or quad precision.
 * Assumes the operand is right-aligned in a 128-bit word; the caller
 * registers every output.
 */
`timescale 1ns/1ps
module fp_field_decoder
    import operand_format_pkg::*;
(
    input wire fp_fmt_t fmt,
    input wire logic [127:0] operand,
    output logic sign,
    output logic [14:0] exp_field,
    output logic [111:0] frac_field,
    output logic signed [16:0] exp_unbiased,
    output logic [5:0] class_onehot
);

    // ************************************************************
    // Field extraction
    // ************************************************************
    wire is_single = (fmt == FMT_SINGLE);
    wire is_double = (fmt == FMT_DOUBLE);
    // Fraction right-aligned so the numeric value is unchanged per format
    wire [111:0] sp_frac = {89'h0, operand[22:0]};
    wire [111:0] dp_frac = {60'h0, operand[51:0]};
    wire [14:0] sp_exp = {7'h00, operand[30:23]};
    wire [14:0] dp_exp = {4'h0, operand[62:52]};
    wire [14:0] exp_max = is_single ? SP_EXP_MAX : (is_double ? DP_EXP_MAX : QP_EXP_MAX);
    wire signed [16:0] bias = is_single ? SP_BIAS : (is_double ? DP_BIAS : QP_BIAS);
    // Leading fraction bit separates quiet from signalling NaN
    wire frac_msb = is_single ? operand[22] : (is_double ? operand[51] : operand[111]);

    assign sign = is_single ? operand[31] : (is_double ? operand[63] : operand[127]);
    assign exp_field = is_single ? sp_exp : (is_double ? dp_exp : operand[126:112]);
    assign frac_field = is_single ? sp_frac : (is_double ? dp_frac : operand[111:0]);

    // ************************************************************
    // Classification
    // ************************************************************
    wire exp_zero = (exp_field == 15'h0000);
    wire exp_ones = (exp_field == exp_max);
    wire frac_zero = (frac_field == 112'h0);

    assign class_onehot[CLS_NORMAL] = !exp_zero && !exp_ones;
    assign class_onehot[CLS_SUBNORMAL] = exp_zero && !frac_zero;
    assign class_onehot[CLS_ZERO] = exp_zero && frac_zero;
    assign class_onehot[CLS_INF] = exp_ones && frac_zero;
    assign class_onehot[CLS_SNAN] = exp_ones && !frac_msb && !frac_zero;
    assign class_onehot[CLS_QNAN] = exp_ones && frac_msb;

    // Subnormals use the smallest normal exponent with no hidden one
    wire signed [16:0] exp_ext = $signed({2'b00, exp_field});
    assign exp_unbiased = class_onehot[CLS_NORMAL] ? 17'(exp_ext - bias) :
                          (class_onehot[CLS_SUBNORMAL] ? 17'(UEXP_ONE - bias) : 17'sh00000);

endmodule : fp_field_decoder

// File: verilog/operand_format_classifier.sv
/*
 * Operand format block of the core datapath: decodes floating-point
 * operands, places integer and floating values into register words and
 * memory images, adds packed SIMD lanes and splits tagged words.
 * Assumes all inputs are synchronous to clock; every result appears one
 * clock after its inputs and stays until the inputs change.
 */
`timescale 1ns/1ps

module operand_format_classifier
    import operand_format_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    // Floating-point operand side
    input wire fp_fmt_t fp_fmt,
    input wire logic [127:0] fp_operand,
    input wire logic [5:0] fp_reg_num,
    input wire logic [3:0] fp_mem_addr,
    // Integer operand side
    input wire int_width_t int_width,
    input wire logic int_signed,
    input wire logic [63:0] int_operand,
    input wire logic little_endian,
    // Packed lane side
    input wire simd_fmt_t simd_fmt,
    input wire logic [63:0] simd_a,
    input wire logic [63:0] simd_b,
    // Tagged word
    input wire logic [31:0] tagged_word,
    // Floating-point results
    output logic fp_sign,
    output logic [14:0] fp_exp,
    output logic [111:0] fp_frac,
    output logic signed [16:0] fp_exp_unbiased,
    output logic [5:0] fp_class,
    output logic [31:0] double_fp_word_high,
    output logic [31:0] double_fp_word_low,
    output logic [31:0] quad_fp_word_first,
    output logic [31:0] quad_fp_word_second,
    output logic [31:0] quad_fp_word_third,
    output logic [31:0] quad_fp_word_fourth,
    output logic fp_reg_legal,
    output logic fp_mem_legal,
    output logic fp_mem_preferred,
    // Integer results
    output logic [63:0] signed_extword,
    output logic [63:0] unsigned_extword,
    output logic [31:0] signed_dword_high,
    output logic [31:0] signed_dword_low,
    output logic [31:0] unsigned_dword_high,
    output logic [31:0] unsigned_dword_low,
    output logic [63:0] mem_dword_image,
    // Packed lane result
    output logic [63:0] simd_sum,
    // Tagged word results
    output logic [1:0] tag_bits,
    output logic tag_nonzero,
    output logic [63:0] tag_value
);

    // ************************************************************
    // Floating-point field decode
    // ************************************************************
    logic dec_sign;                 // Sign from the selected format
    logic [14:0] dec_exp;           // Biased exponent, zero-extended
    logic [111:0] dec_frac;         // Fraction, right-aligned
    logic signed [16:0] dec_uexp;   // Unbiased exponent
    logic [5:0] dec_class;          // One-hot class

    // Shared decoder keeps one classification path for all formats
    fp_field_decoder u_decoder (
        .fmt(fp_fmt),
        .operand(fp_operand),
        .sign(dec_sign),
        .exp_field(dec_exp),
        .frac_field(dec_frac),
        .exp_unbiased(dec_uexp),
        .class_onehot(dec_class)
    );

    // ************************************************************
    // Floating-point register and memory placement
    // ************************************************************
    // Single precision only names the lower half of the file
    wire single_reg_ok = (fp_reg_num <= FP_SINGLE_DIRECT_MAX);
    // Double needs an even register, quad a multiple of four
    wire double_reg_ok = (fp_reg_num[0] == 1'b0);
    wire quad_reg_ok = (fp_reg_num[1:0] == 2'b00);
    wire next_reg_legal = (fp_fmt == FMT_SINGLE) ? single_reg_ok :
                          ((fp_fmt == FMT_DOUBLE) ? double_reg_ok : quad_reg_ok);
    // Word alignment is all that is required; wider is only faster
    wire next_mem_legal = ((fp_mem_addr & WORD_ALIGN_MASK) == 4'h0);
    wire [3:0] pref_mask = (fp_fmt == FMT_SINGLE) ? WORD_ALIGN_MASK :
                           ((fp_fmt == FMT_DOUBLE) ? DWORD_ALIGN_MASK : QUAD_ALIGN_MASK);
    wire next_mem_preferred = ((fp_mem_addr & pref_mask) == 4'h0);

    // ************************************************************
    // Integer width extension
    // ************************************************************
    // Narrow data is widened into a full 64-bit register entry
    wire [63:0] next_sext = (int_width == INT_BYTE) ? {{56{int_operand[7]}}, int_operand[7:0]} :
                            (int_width == INT_HALF) ? {{48{int_operand[15]}}, int_operand[15:0]} :
                            (int_width == INT_WORD) ? {{32{int_operand[31]}}, int_operand[31:0]} :
                            int_operand;
    wire [63:0] next_zext = (int_width == INT_BYTE) ? {56'h0, int_operand[7:0]} :
                            (int_width == INT_HALF) ? {48'h0, int_operand[15:0]} :
                            (int_width == INT_WORD) ? {32'h0, int_operand[31:0]} :
                            int_operand;
    // One memory image serves both doubleword and extended-word views
    wire [63:0] mem_source = int_signed ? next_sext : next_zext;

    // ************************************************************
    // Per-byte logic: lane adders and byte reversal
    // ************************************************************
    // Lane boundaries cut the carry chain; a binary point has no effect
    wire [7:0] lane_start = (simd_fmt == SIMD_PACKED_UNSIGNED_BYTE_LANES) ? LANE_START_PACKED_UNSIGNED_BYTE_LANES :
                            ((simd_fmt == SIMD_PACKED_SIGNED_HALF_LANES) ? LANE_START_PACKED_SIGNED_HALF_LANES : LANE_START_PACKED_SIGNED_WORD_LANES);
    wire [8:0] carry;               // Carry into each byte
    wire [63:0] lane_sum;           // Raw per-byte sums
    wire [63:0] mem_swapped;        // Byte-reversed image
    assign carry[0] = 1'b0;

    genvar gi;
    generate
        for (gi = 0; gi < BYTE_LANES; gi = gi + 1) begin : g_byte
            // Carry only flows within one lane
            wire cin = lane_start[gi] ? 1'b0 : carry[gi];
            wire [8:0] byte_sum = {1'b0, simd_a[8*gi +: 8]} + {1'b0, simd_b[8*gi +: 8]}
                                  + {8'h00, cin};
            assign lane_sum[8*gi +: 8] = byte_sum[7:0];
            assign carry[gi+1] = byte_sum[8];
            // Reversing bytes of 64 bits also reverses the word order
            assign mem_swapped[8*gi +: 8] = mem_source[8*(7-gi) +: 8];
        end
    endgenerate

    // Byte lanes occupy only the low word; the high word reads zero
    wire [63:0] next_simd = (simd_fmt == SIMD_PACKED_UNSIGNED_BYTE_LANES) ? {32'h0, lane_sum[31:0]} :
                            lane_sum;
    wire [63:0] next_mem_image = little_endian ? mem_swapped : mem_source;

    // ************************************************************
    // Tagged word split
    // ************************************************************
    // Upper 30 bits are a signed value, extended to a full entry
    wire [63:0] next_tag_value = {{34{tagged_word[31]}}, tagged_word[31:2]};

    // ************************************************************
    // Output registers
    // ************************************************************
    // Floating decode results, one clock after the operand
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fp_sign <= 1'b0;
            fp_exp <= 15'h0000;
            fp_frac <= 112'h0;
            fp_exp_unbiased <= 17'sh00000;
            fp_class <= CLS_RESET;
        end else begin
            fp_sign <= dec_sign;
            fp_exp <= dec_exp;
            fp_frac <= dec_frac;
            fp_exp_unbiased <= dec_uexp;
            fp_class <= dec_class;
        end
    end

    // Floating register words; a double uses the low 64 operand bits
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            double_fp_word_high <= 32'h0;
            double_fp_word_low <= 32'h0;
            quad_fp_word_first <= 32'h0;
            quad_fp_word_second <= 32'h0;
            quad_fp_word_third <= 32'h0;
            quad_fp_word_fourth <= 32'h0;
        end else begin
            double_fp_word_high <= fp_operand[63:32];
            double_fp_word_low <= fp_operand[31:0];
            quad_fp_word_first <= fp_operand[127:96];
            quad_fp_word_second <= fp_operand[95:64];
            quad_fp_word_third <= fp_operand[63:32];
            quad_fp_word_fourth <= fp_operand[31:0];
        end
    end

    // Legality flags for register number and memory address
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fp_reg_legal <= 1'b0;
            fp_mem_legal <= 1'b0;
            fp_mem_preferred <= 1'b0;
        end else begin
            fp_reg_legal <= next_reg_legal;
            fp_mem_legal <= next_mem_legal;
            fp_mem_preferred <= next_mem_preferred;
        end
    end

    // Integer words: the pair split goes high half to the even register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            signed_extword <= 64'h0;
            unsigned_extword <= 64'h0;
            signed_dword_high <= 32'h0;
            signed_dword_low <= 32'h0;
            unsigned_dword_high <= 32'h0;
            unsigned_dword_low <= 32'h0;
            mem_dword_image <= 64'h0;
        end else begin
            signed_extword <= next_sext;
            unsigned_extword <= next_zext;
            signed_dword_high <= next_sext[63:32];
            signed_dword_low <= next_sext[31:0];
            unsigned_dword_high <= next_zext[63:32];
            unsigned_dword_low <= next_zext[31:0];
            mem_dword_image <= next_mem_image;
        end
    end

    // Packed lane sum and tagged word fields
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            simd_sum <= 64'h0;
            tag_bits <= 2'b00;
            tag_nonzero <= 1'b0;
            tag_value <= 64'h0;
        end else begin
            simd_sum <= next_simd;
            tag_bits <= tagged_word[TAG_W-1:0];
            tag_nonzero <= (tagged_word[TAG_W-1:0] != 2'b00);
            tag_value <= next_tag_value;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    // A class is always present and never two at once
    AST_CLASS_ONEHOT: assert property ($onehot(fp_class))
        else $error("class output not one-hot");

    // Single exponent 128 means unbiased exponent 1
    AST_SINGLE_NORMAL: assert property (
        (fp_fmt == FMT_SINGLE && fp_operand[30:23] == 8'h80)
        |=> (fp_class[CLS_NORMAL] && fp_exp_unbiased == 17'sh00001))
        else $error("single normal exponent wrong");

    // Single subnormal reports exponent -126
    AST_SINGLE_SUBNORMAL: assert property (
        (fp_fmt == FMT_SINGLE && fp_operand[30:23] == 8'h00 && fp_operand[22:0] != 23'h0)
        |=> (fp_class[CLS_SUBNORMAL] && fp_exp_unbiased == -17'sd126))
        else $error("single subnormal decode wrong");

    // Single signalling NaN regardless of sign
    AST_SINGLE_SNAN: assert property (
        (fp_fmt == FMT_SINGLE && fp_operand[30:23] == 8'hff && !fp_operand[22]
         && fp_operand[21:0] != 22'h0)
        |=> fp_class[CLS_SNAN])
        else $error("signalling NaN not detected");

    // Double quiet NaN and its 11-bit exponent field
    AST_DOUBLE_QNAN: assert property (
        (fp_fmt == FMT_DOUBLE && fp_operand[62:52] == 11'h7ff && fp_operand[51])
        |=> (fp_class[CLS_QNAN] && fp_exp == 15'h07ff))
        else $error("double quiet NaN not detected");

    // Quad infinity carries the operand sign
    AST_QUAD_INF: assert property (
        (fp_fmt == FMT_QUAD && fp_operand[126:112] == 15'h7fff && fp_operand[111:0] == 112'h0)
        |=> (fp_class[CLS_INF] && fp_sign == $past(fp_operand[127])))
        else $error("quad infinity decode wrong");

    // Quad subnormal exponent is -16382
    AST_QUAD_SUBNORMAL: assert property (
        (fp_fmt == FMT_QUAD && fp_operand[126:112] == 15'h0000 && fp_operand[0])
        |=> (fp_exp_unbiased == -17'sd16382))
        else $error("quad subnormal exponent wrong");

    // Single precision beyond register 31 is illegal
    AST_SINGLE_REG: assert property (
        (fp_fmt == FMT_SINGLE && fp_reg_num[5]) |=> !fp_reg_legal)
        else $error("single register above 31 accepted");

    // Signed high and unsigned low doubleword halves follow the operand
    AST_DWORD_SPLIT: assert property (
        (int_width == INT_DWORD)
        |=> (signed_dword_high == $past(int_operand[63:32])
             && unsigned_dword_low == $past(int_operand[31:0])))
        else $error("doubleword split wrong");

    // Little-endian image starts with the least significant byte
    AST_ENDIAN_SWAP: assert property (
        (little_endian && int_width == INT_DWORD)
        |=> (mem_dword_image[63:56] == $past(int_operand[7:0])
             && mem_dword_image[7:0] == $past(int_operand[63:56])))
        else $error("little-endian image wrong");

    // Halfword lanes wrap without carrying into the next lane
    AST_HALF_LANE: assert property (
        (simd_fmt == SIMD_PACKED_SIGNED_HALF_LANES && simd_a[15:0] == 16'hffff && simd_b[15:0] == 16'h0001)
        |=> (simd_sum[31:0] == $past(simd_a[31:16] + simd_b[31:16]) << 16))
        else $error("halfword lane carry leaked");

    // Tagged value is the upper 30 bits, sign-extended
    AST_TAG_VALUE: assert property (
        1'b1 |=> (tag_value[29:0] == $past(tagged_word[31:2])
                  && tag_value[63] == $past(tagged_word[31])))
        else $error("tagged value wrong");

    COV_QNAN: cover property (fp_class[CLS_QNAN]);
    COV_SUBNORMAL: cover property (fp_class[CLS_SUBNORMAL]);
    COV_LITTLE_ENDIAN: cover property (little_endian ##1 mem_dword_image != 64'h0);
    COV_BYTE_LANES: cover property (simd_fmt == SIMD_PACKED_UNSIGNED_BYTE_LANES ##1 simd_sum != 64'h0);

endmodule : operand_format_classifier

// File: dv/testbench.sv
/* Bench for operand_format_classifier: drives every input and queues results.
   Assumes results one clock after inputs and an async active-low reset. */
`timescale 1ns/1ps
module testbench;
    import operand_format_pkg::*;
    typedef struct {int cyc; string nm; logic [319:0] ex;} note_t;
    note_t q[$];
    note_t nt;
    fp_fmt_t fp_fmt;
    int_width_t int_width;
    simd_fmt_t simd_fmt;
    logic clock, rst_b, int_signed, little_endian, fp_sign, fp_reg_legal;
    logic fp_mem_legal, fp_mem_preferred, tag_nonzero;
    logic [1:0] tag_bits;
    logic [3:0] fp_mem_addr;
    logic [5:0] fp_reg_num, fp_class;
    logic [14:0] fp_exp;
    logic signed [16:0] fp_exp_unbiased;
    logic [31:0] tagged_word, double_fp_word_high, double_fp_word_low, quad_fp_word_first;
    logic [31:0] quad_fp_word_second, quad_fp_word_third, quad_fp_word_fourth;
    logic [31:0] signed_dword_high, signed_dword_low, unsigned_dword_high, unsigned_dword_low;
    logic [63:0] int_operand, simd_a, simd_b, signed_extword, unsigned_extword;
    logic [63:0] mem_dword_image, simd_sum, tag_value, v, m;
    logic [111:0] fp_frac;
    logic [127:0] fp_operand, fr, msb;
    logic [31:0] seed = 32'h000005e9;
    string g[4] = '{"word", "int", "simd", "tag"};
    int cnt, errors, n_tests, f, c, ew, fw, e, bias, lw;
    operand_format_classifier uut (.*);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Output groups as the monitor compares them
    function automatic logic [319:0] seen(string n);
        case (n)
            "fp": return {fp_class, fp_sign, fp_exp, $unsigned(fp_exp_unbiased), fp_frac,
                fp_reg_legal, fp_mem_legal, fp_mem_preferred};
            "word": return {double_fp_word_high, double_fp_word_low, quad_fp_word_first,
                quad_fp_word_second, quad_fp_word_third, quad_fp_word_fourth};
            "int": return {signed_extword, unsigned_extword, signed_dword_high,
                signed_dword_low, unsigned_dword_high, unsigned_dword_low, mem_dword_image};
            "simd": return simd_sum;
            default: return {tag_bits, tag_nonzero, tag_value};
        endcase
    endfunction : seen
    // Queue one expected group; it falls due d monitor ticks from now
    task automatic note(string n, logic [319:0] x, int d = 2);
        q.push_back(note_t'{cnt + d, n, x});
    endtask : note
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    // 40 MHz core clock
    initial begin
        clock = 0;
        forever #12.5 clock = ~clock;
    end
    // Monitor: a note falls due one edge after its inputs were driven
    always @(posedge clock) begin
        #2;
        cnt++;
        while (q.size() > 0 && q[0].cyc <= cnt) begin
            nt = q.pop_front();
            n_tests++;
            if (seen(nt.nm) !== nt.ex) begin
                errors++;
                $display("[ERR] %s expected %h seen %h", nt.nm, nt.ex, seen(nt.nm));
            end
        end
    end
    // Back-to-back operands, a new format every cycle and a new class every third cycle
    task automatic sweep(int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            #1;
            f = i % 3;
            c = (i / 3) % 6;
            ew = f == 0 ? 8 : f == 1 ? 11 : 15;
            fw = f == 0 ? 23 : f == 1 ? 52 : 112;
            bias = (1 << (ew - 1)) - 1;
            // First normal of each format sits just above the bias
            e = c == 0 ? (i < 3 ? bias + 1 : 1 + rnd() % ((1 << ew) - 2)) :
                c < 3 ? 0 : (1 << ew) - 1;
            msb = 128'h1 << (fw - 1);
            fr = {rnd(), rnd(), rnd(), rnd()} & ((msb << 1) - 1);
            fr = c == 2 || c == 3 ? 0 : c == 4 ? (fr & ~msb) | 1 : c == 5 ? fr | msb : fr | c;
            fp_fmt = fp_fmt_t'(f);
            fp_operand = ({rnd(), rnd(), rnd(), rnd()} << (ew + fw)) | (128'(e) << fw) | fr;
            fp_reg_num = 6'(rnd());
            fp_mem_addr = 4'(rnd());
            note("fp", {6'(1 << c), fp_operand[ew + fw], 15'(e),
                17'(c == 0 ? e - bias : c == 1 ? 1 - bias : 0), fr[111:0],
                f > 0 ? (fp_reg_num & 6'(2 * f - 1)) == 0 : fp_reg_num <= 31,
                fp_mem_addr[1:0] == 0,
                (fp_mem_addr & 4'((4 << f) - 1)) == 0});
            note("word", {fp_operand[63:0], fp_operand});
            int_width = int_width_t'(i % 4);
            int_operand = {rnd(), rnd()};
            int_signed = 1'(rnd());
            little_endian = 1'(rnd());
            m = (64'h1 << (8 << (i % 4))) - 1;
            v = int_operand & m;
            fr = v | ((|(v & ~(m >> 1))) ? ~m : 64'h0);
            m = int_signed ? fr[63:0] : v;
            if (little_endian) m = {<<8{m}};
            note("int", {fr[63:0], v,
                fr[63:0], v, m});
            simd_fmt = simd_fmt_t'(i % 3);
            simd_a = {rnd(), rnd()};
            simd_b = {rnd(), rnd()};
            // A full low halfword plus one must not carry into the next lane
            if (i == 4) {simd_a[15:0], simd_b[15:0]} = 32'hffff_0001;
            lw = 8 << (i % 3);
            v = '0;
            for (int k = 0; k < (i % 3 == 2 ? 2 : 4); k++) begin
                m = ((simd_a >> (k * lw)) + (simd_b >> (k * lw))) & ((64'h1 << lw) - 1);
                v |= m << (k * lw);
            end
            note("simd", v);
            tagged_word = rnd();
            v = $signed(tagged_word[31:2]);
            note("tag", {tagged_word[1:0], |tagged_word[1:0], v});
        end
    endtask : sweep
    // Watchdog: the whole run needs well under 100 cycles
    initial begin
        #(25 * 400);
        errors++;
        give_verdict();
    end
    initial begin
        rst_b = 0;
        sweep(1);
        q.delete();
        repeat (4) @(posedge clock);
        #1;
        rst_b = 1;
        sweep(36);
        $display("Format sweep done");
        // Let the last sweep results be compared before reset clears them
        repeat (2) @(posedge clock);
        #1;
        rst_b = 0;
        note("fp", {6'h04, 148'h0}, 1);
        foreach (g[k]) note(g[k], 0, 1);
        repeat (2) @(posedge clock);
        #1;
        rst_b = 1;
        sweep(6);
        repeat (3) @(posedge clock);
        $display("Reset and recovery done");
        give_verdict();
    end
endmodule : testbench
